/* iev_pkg.sv */
// Purpose: Shared constants and types for the interrupt enable and vector unit
// Assumes: Special-function-register bus with 8-bit data and bit addressing
// Notes: Vector numbers index all per-source vectors; number 9 carries no source
package iev_pkg;

  // Register addresses
  localparam logic [7:0] IEV_ADDR_EXT_A = 8'h9b;
  localparam logic [7:0] IEV_ADDR_EXT_B = 8'h9c;
  localparam logic [7:0] IEV_ADDR_PRIMARY = 8'ha8;

  // Reset values
  localparam logic [7:0] IEV_RST_EXT_A = 8'h00;
  localparam logic [7:0] IEV_RST_EXT_B = 8'h00;
  localparam logic [7:0] IEV_RST_PRIMARY = 8'h00;

  // Writable bit masks, reserved bits read as zero
  localparam logic [7:0] IEV_MASK_EXT_A = 8'hbf;
  localparam logic [7:0] IEV_MASK_EXT_B = 8'h07;
  localparam logic [7:0] IEV_MASK_PRIMARY = 8'hff;

  // Field positions in the primary enable register
  localparam int IEV_BIT_GLOBAL = 7;
  localparam int IEV_BIT_CONV = 6;
  localparam int IEV_BIT_BROWNOUT = 5;
  localparam int IEV_BIT_SERIAL0 = 4;
  localparam int IEV_BIT_TIMER1 = 3;
  localparam int IEV_BIT_EXTPIN1 = 2;
  localparam int IEV_BIT_TIMER0 = 1;
  localparam int IEV_BIT_EXTPIN0 = 0;

  // Field positions in extended enable register A
  localparam int IEV_BIT_TIMER2_D = 7;
  localparam int IEV_BIT_TIMER2_C = 5;
  localparam int IEV_BIT_WATCHDOG = 4;
  localparam int IEV_BIT_TIMER2_B = 3;
  localparam int IEV_BIT_TIMER2_A = 2;
  localparam int IEV_BIT_PINCHANGE = 1;
  localparam int IEV_BIT_TWOWIRE = 0;

  // Field positions in extended enable register B
  localparam int IEV_BIT_WAKEUP = 2;
  localparam int IEV_BIT_TIMER3 = 1;
  localparam int IEV_BIT_SERIAL1 = 0;

  // Vector numbers
  localparam int IEV_NUM_VEC = 18;
  localparam logic [4:0] IEV_VEC_EXTPIN0 = 5'h00;
  localparam logic [4:0] IEV_VEC_TIMER0 = 5'h01;
  localparam logic [4:0] IEV_VEC_EXTPIN1 = 5'h02;
  localparam logic [4:0] IEV_VEC_UNUSED = 5'h09;

  // Vector address layout
  localparam logic [15:0] IEV_RESET_VECTOR = 16'h0000;
  localparam logic [15:0] IEV_VEC_BASE = 16'h0003;
  localparam int IEV_VEC_STRIDE_SHIFT = 3;

  // Sources in natural priority order, element 0 highest
  localparam int IEV_NUM_SRC = 17;
  localparam logic [16:0][4:0] IEV_NAT_ORDER = {
    5'h11, 5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h05, 5'h04, 5'h03,
    5'h07, 5'h02, 5'h0b, 5'h06, 5'h01, 5'h0a, 5'h08, 5'h00};

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_wr;
    logic [7:0] bit_addr;
    logic bit_val;
  } iev_sfr_req_t;

  // Peripheral flag bundle
  typedef struct packed {
    logic [1:0] serial0;
    logic [1:0] serial1;
    logic twowire_status;
    logic twowire_timeout_flag;
    logic [7:0] pinchange_flag_reg;
    logic conv_done_flag;
    logic brownout_flag;
    logic watchdog_flag;
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic timer3_overflow_flag;
    logic wakeup_timer_flag;
    logic [3:0] timer2_flags;
  } iev_flags_t;

  // Vector address for a vector number
  function automatic logic [15:0] iev_vec_addr(input logic [4:0] num);
    iev_vec_addr = IEV_VEC_BASE + ({11'h000, num} << IEV_VEC_STRIDE_SHIFT);
  endfunction : iev_vec_addr

endpackage : iev_pkg

/* iev_arbiter.sv */
// Purpose: Picks the winning request by level, then by natural priority
// Assumes: Requests already gated by their enables
// Notes: Purely combinational
`timescale 1ns/1ps
module iev_arbiter
  import iev_pkg::*;
(
  // Requests and levels
  input wire logic [IEV_NUM_VEC-1:0] i_req,
  input wire logic [IEV_NUM_VEC-1:0] i_prio_high,
  input wire logic [IEV_NUM_VEC-1:0] i_prio_low,
  // Winner
  output logic o_valid,
  output logic [4:0] o_num,
  output logic [1:0] o_level
);

  logic [4:0] src;
  logic [1:0] lvl;

  // Scan from lowest natural priority, so later equal levels win ties
  always_comb
  begin
    o_valid = 1'b0;
    o_num = 5'h00;
    o_level = 2'h0;
    src = 5'h00;
    lvl = 2'h0;
    for (int k = IEV_NUM_SRC - 1; k >= 0; k--)
    begin
      src = IEV_NAT_ORDER[k];
      lvl = {i_prio_high[src], i_prio_low[src]};
      if (i_req[src] && (!o_valid || lvl >= o_level))
      begin
        o_valid = 1'b1;
        o_num = src;
        o_level = lvl;
      end
    end
  end

endmodule : iev_arbiter

/* iev_unit.sv */
// Purpose: Interrupt enable registers, request gating, vector selection, service nesting
// Assumes: Core samples o_vector_valid and jumps; peripherals clear flags on o_service_ack
// Notes: Flags stay pending in the peripherals until cleared
`timescale 1ns/1ps
module iev_unit
  import iev_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register bus
  input wire iev_sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  // Peripheral flags and priority bits
  input wire iev_flags_t i_flags,
  input wire logic [IEV_NUM_VEC-1:0] i_prio_high,
  input wire logic [IEV_NUM_VEC-1:0] i_prio_low,
  // External interrupt pins
  input wire logic [1:0] i_extpin_n,
  input wire logic [1:0] i_extpin_edge_select,
  input wire logic [1:0] i_extpin_flag_sw_we,
  input wire logic [1:0] i_extpin_flag_sw_val,
  output logic [1:0] o_extpin_request_flag,
  // Core handshake
  input wire logic i_insn_boundary,
  input wire logic i_return_from_service,
  output logic o_vector_valid,
  output logic [15:0] o_vector_addr,
  output logic [4:0] o_vector_num,
  output logic [IEV_NUM_VEC-1:0] o_service_ack,
  output logic [3:0] o_in_service
);

  // Register file state
  logic [7:0] primary_enable_q, primary_enable_d;
  logic [7:0] extended_enable_a_q, extended_enable_a_d;
  logic [7:0] extended_enable_b_q, extended_enable_b_d;
  logic [7:0] rdata_d;
  logic hit_d;

  // Extpin state
  logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [1:0] ext_flag_q, ext_flag_d;

  // Request and service state
  logic [IEV_NUM_VEC-1:0] flag_raw, allow, req_q, req_d;
  logic [3:0] isr_q, isr_d;
  logic vv_q, vv_d;
  logic [15:0] va_q, va_d;
  logic [4:0] vn_q, vn_d;
  logic [IEV_NUM_VEC-1:0] ack_q, ack_d;
  logic win_valid;
  logic [4:0] win_num;
  logic [1:0] win_level;
  logic [1:0] cur_level;
  logic take;

  // Register read decode, reserved bits read zero
  function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic [7:0] pe,
                                          input logic [7:0] ea, input logic [7:0] eb);
    case (addr)
      IEV_ADDR_PRIMARY: read_reg = pe;
      IEV_ADDR_EXT_A: read_reg = ea & IEV_MASK_EXT_A;
      IEV_ADDR_EXT_B: read_reg = eb & IEV_MASK_EXT_B;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // Register writes, byte and bit forms
  always_comb
  begin
    primary_enable_d = primary_enable_q;
    extended_enable_a_d = extended_enable_a_q;
    extended_enable_b_d = extended_enable_b_q;
    if (i_sfr.wr)
    begin
      if (i_sfr.addr == IEV_ADDR_PRIMARY)
        primary_enable_d = i_sfr.wdata & IEV_MASK_PRIMARY;
      if (i_sfr.addr == IEV_ADDR_EXT_A)
        extended_enable_a_d = i_sfr.wdata & IEV_MASK_EXT_A;
      if (i_sfr.addr == IEV_ADDR_EXT_B)
        extended_enable_b_d = i_sfr.wdata & IEV_MASK_EXT_B;
    end
    if (i_sfr.bit_wr && i_sfr.bit_addr[7:3] == IEV_ADDR_PRIMARY[7:3])
      primary_enable_d[i_sfr.bit_addr[2:0]] = i_sfr.bit_val;
    rdata_d = i_sfr.rd ? read_reg(i_sfr.addr, primary_enable_q, extended_enable_a_q,
                                  extended_enable_b_q) : o_sfr_rdata;
    hit_d = i_sfr.rd && (i_sfr.addr == IEV_ADDR_PRIMARY || i_sfr.addr == IEV_ADDR_EXT_A ||
                         i_sfr.addr == IEV_ADDR_EXT_B);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      primary_enable_q <= IEV_RST_PRIMARY;
      extended_enable_a_q <= IEV_RST_EXT_A;
      extended_enable_b_q <= IEV_RST_EXT_B;
      o_sfr_rdata <= 8'h00;
      o_sfr_hit <= 1'b0;
    end
    else
    begin
      primary_enable_q <= primary_enable_d;
      extended_enable_a_q <= extended_enable_a_d;
      extended_enable_b_q <= extended_enable_b_d;
      o_sfr_rdata <= rdata_d;
      o_sfr_hit <= hit_d;
    end
  end

  // External pin flags: falling edge sets in edge mode, inverse pin in level mode
  always_comb
  begin
    ext_flag_d = ext_flag_q;
    for (int p = 0; p < 2; p++)
    begin
      if (!i_extpin_edge_select[p])
        ext_flag_d[p] = ~pin_s2_q[p];
      else
      begin
        if (i_extpin_flag_sw_we[p])
          ext_flag_d[p] = i_extpin_flag_sw_val[p];
        if (take && win_num == (p == 0 ? IEV_VEC_EXTPIN0 : IEV_VEC_EXTPIN1))
          ext_flag_d[p] = 1'b0;
        if (pin_s3_q[p] && !pin_s2_q[p])
          ext_flag_d[p] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_s1_q <= 2'h3;
      pin_s2_q <= 2'h3;
      pin_s3_q <= 2'h3;
      ext_flag_q <= 2'h0;
      o_extpin_request_flag <= 2'h0;
    end
    else
    begin
      pin_s1_q <= i_extpin_n;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      ext_flag_q <= ext_flag_d;
      o_extpin_request_flag <= ext_flag_d;
    end
  end

  // Source flags by vector number
  always_comb
  begin
    flag_raw = '0;
    flag_raw[0] = ext_flag_q[0];
    flag_raw[1] = i_flags.timer0_overflow_flag;
    flag_raw[2] = ext_flag_q[1];
    flag_raw[3] = i_flags.timer1_overflow_flag;
    flag_raw[4] = |i_flags.serial0;
    flag_raw[5] = i_flags.timer2_flags[0];
    flag_raw[6] = i_flags.twowire_status | i_flags.twowire_timeout_flag;
    flag_raw[7] = |i_flags.pinchange_flag_reg;
    flag_raw[8] = i_flags.brownout_flag;
    flag_raw[10] = i_flags.watchdog_flag;
    flag_raw[11] = i_flags.conv_done_flag;
    flag_raw[12] = i_flags.timer2_flags[1];
    flag_raw[13] = i_flags.timer2_flags[2];
    flag_raw[14] = i_flags.timer2_flags[3];
    flag_raw[15] = |i_flags.serial1;
    flag_raw[16] = i_flags.timer3_overflow_flag;
    flag_raw[17] = i_flags.wakeup_timer_flag;
  end

  // Individual enables by vector number
  always_comb
  begin
    allow = '0;
    allow[0] = primary_enable_q[IEV_BIT_EXTPIN0];
    allow[1] = primary_enable_q[IEV_BIT_TIMER0];
    allow[2] = primary_enable_q[IEV_BIT_EXTPIN1];
    allow[3] = primary_enable_q[IEV_BIT_TIMER1];
    allow[4] = primary_enable_q[IEV_BIT_SERIAL0];
    allow[5] = extended_enable_a_q[IEV_BIT_TIMER2_A];
    allow[6] = extended_enable_a_q[IEV_BIT_TWOWIRE];
    allow[7] = extended_enable_a_q[IEV_BIT_PINCHANGE];
    allow[8] = primary_enable_q[IEV_BIT_BROWNOUT];
    allow[10] = extended_enable_a_q[IEV_BIT_WATCHDOG];
    allow[11] = primary_enable_q[IEV_BIT_CONV];
    allow[12] = extended_enable_a_q[IEV_BIT_TIMER2_B];
    allow[13] = extended_enable_a_q[IEV_BIT_TIMER2_C];
    allow[14] = extended_enable_a_q[IEV_BIT_TIMER2_D];
    allow[15] = extended_enable_b_q[IEV_BIT_SERIAL1];
    allow[16] = extended_enable_b_q[IEV_BIT_TIMER3];
    allow[17] = extended_enable_b_q[IEV_BIT_WAKEUP];
  end

  // Registered requests; flags stay pending in the peripherals meanwhile
  assign req_d = flag_raw & allow;

  iev_arbiter u_arb (
    .i_req(req_q),
    .i_prio_high(i_prio_high),
    .i_prio_low(i_prio_low),
    .o_valid(win_valid),
    .o_num(win_num),
    .o_level(win_level)
  );

  // Highest level currently in service
  always_comb
  begin
    cur_level = 2'h0;
    for (int l = 0; l < 4; l++)
      if (isr_q[l])
        cur_level = 2'(l);
  end

  // Take only at a boundary, globally enabled, not on a return cycle
  assign take = i_insn_boundary && !i_return_from_service && win_valid
                && primary_enable_q[IEV_BIT_GLOBAL]
                && (isr_q == 4'h0 || win_level > cur_level);

  always_comb
  begin
    isr_d = isr_q;
    if (i_return_from_service && isr_q != 4'h0)
      isr_d[cur_level] = 1'b0;
    else if (take)
      isr_d[win_level] = 1'b1;
    vv_d = take;
    va_d = take ? iev_vec_addr(win_num) : va_q;
    vn_d = take ? win_num : vn_q;
    ack_d = '0;
    if (take)
      ack_d[win_num] = 1'b1;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      req_q <= '0;
      isr_q <= 4'h0;
      vv_q <= 1'b0;
      va_q <= IEV_RESET_VECTOR;
      vn_q <= 5'h00;
      ack_q <= '0;
    end
    else
    begin
      req_q <= req_d;
      isr_q <= isr_d;
      vv_q <= vv_d;
      va_q <= va_d;
      vn_q <= vn_d;
      ack_q <= ack_d;
    end
  end

  assign o_vector_valid = vv_q;
  assign o_vector_addr = va_q;
  assign o_vector_num = vn_q;
  assign o_service_ack = ack_q;
  assign o_in_service = isr_q;
  // Checks
  sequence s_take;
    i_insn_boundary && win_valid && primary_enable_q[IEV_BIT_GLOBAL] && !i_return_from_service;
  endsequence

  property p_global_gate;
    @(posedge i_clk) disable iff (i_rst)
    o_vector_valid |-> $past(primary_enable_q[IEV_BIT_GLOBAL]) && $past(i_insn_boundary);
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("vector issued while disabled");

  property p_vec_addr;
    @(posedge i_clk) disable iff (i_rst)
    o_vector_valid |-> o_vector_addr == IEV_VEC_BASE + {8'h00, o_vector_num, 3'h0};
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

  property p_unused_vec;
    @(posedge i_clk) disable iff (i_rst)
    o_vector_valid |-> o_vector_num != IEV_VEC_UNUSED && o_vector_num < 5'h12;
  endproperty
  a_unused_vec: assert property (p_unused_vec) else $error("unused vector issued");

  property p_strict_preempt;
    @(posedge i_clk) disable iff (i_rst)
    (take && isr_q != 4'h0) |-> win_level > cur_level ##1 o_vector_valid;
  endproperty
  a_strict_preempt: assert property (p_strict_preempt) else $error("equal level preempted");

  property p_idle_take;
    @(posedge i_clk) disable iff (i_rst)
    (s_take and (isr_q == 4'h0)) |=> o_vector_valid && o_service_ack[o_vector_num] && isr_q != 4'h0;
  endproperty
  a_idle_take: assert property (p_idle_take) else $error("pending request not taken");

  property p_return;
    @(posedge i_clk) disable iff (i_rst)
    (i_return_from_service && isr_q != 4'h0) |=> $countones(isr_q) + 1 == $countones($past(isr_q));
  endproperty
  a_return: assert property (p_return) else $error("return did not end service");

  property p_reserved;
    @(posedge i_clk) disable iff (i_rst)
    extended_enable_b_q[7:3] == 5'h00 && !extended_enable_a_q[6];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved enable bit set");

  property p_edge_clear;
    @(posedge i_clk) disable iff (i_rst)
    (o_service_ack[IEV_VEC_EXTPIN1] && i_extpin_edge_select[1] && $past(i_extpin_edge_select[1])
      && !($past(pin_s3_q[1]) && !$past(pin_s2_q[1])) && !$past(i_extpin_flag_sw_we[1]))
      |-> !ext_flag_q[1];
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge flag not cleared");

  property p_tie_break;
    @(posedge i_clk) disable iff (i_rst)
    (take && req_q[IEV_VEC_EXTPIN0] && i_prio_high[0] && i_prio_low[0]) |-> win_num == IEV_VEC_EXTPIN0;
  endproperty
  a_tie_break: assert property (p_tie_break) else $error("natural order broken");

endmodule : iev_unit

/* iev_core_model.sv */
// Purpose: Core model that takes vectors, runs routines and returns
// Assumes: One return pulse ends each routine; routine length set by bench
// Notes: Slow mode opens an instruction boundary every other cycle
`timescale 1ns/1ps
module iev_core_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Controls
  input wire logic i_vector_valid,
  input wire logic i_slow,
  input wire logic [7:0] i_svc_len,
  // Core side
  output logic o_insn_boundary,
  output logic o_return_from_service,
  output logic [2:0] o_depth
);
  logic [7:0] timer_q;
  logic phase_q;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      timer_q <= 8'h00;
      phase_q <= 1'h0;
      o_insn_boundary <= 1'h0;
      o_return_from_service <= 1'h0;
      o_depth <= 3'h0;
    end
    else
    begin
      phase_q <= ~phase_q;
      // Boundaries between instructions only
      o_insn_boundary <= ~(i_slow & phase_q);
      o_depth <= o_depth + {2'h0, i_vector_valid} - {2'h0, o_return_from_service};
      o_return_from_service <= 1'h0;
      if (i_vector_valid || o_return_from_service)
        timer_q <= i_svc_len;
      else if (timer_q != 8'h00)
        timer_q <= timer_q - 8'h01;
      else if (o_depth != 3'h0)
        // Each routine ends with one return
        o_return_from_service <= 1'h1;
    end
  end
endmodule : iev_core_model

/* tb.sv */
// Purpose: Self-checking bench for the interrupt enable and vector unit
// Assumes: Core model answers vectors; bench plays peripherals and routines
// Notes: Routines clear their own flags
`timescale 1ns/1ps
module tb;
  import iev_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  iev_sfr_req_t sfr;
  iev_flags_t flags;
  logic [17:0] prio_high;
  logic [17:0] prio_low;
  logic [1:0] pin_n;
  logic [1:0] edge_sel;
  logic [1:0] sw_we;
  logic [1:0] sw_val;
  logic boundary;
  logic ret;
  logic slow;
  logic [7:0] svc_len;
  logic [2:0] depth;
  logic [7:0] rdata;
  logic hit;
  logic [1:0] ext_flag;
  logic vec_valid;
  logic [15:0] vec_addr;
  logic [4:0] vec_num;
  logic [17:0] ack;
  logic [3:0] in_svc;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  iev_unit i_iev_unit (
    .i_clk(clk),
    .i_rst(rst),
    .i_sfr(sfr),
    .o_sfr_rdata(rdata),
    .o_sfr_hit(hit),
    .i_flags(flags),
    .i_prio_high(prio_high),
    .i_prio_low(prio_low),
    .i_extpin_n(pin_n),
    .i_extpin_edge_select(edge_sel),
    .i_extpin_flag_sw_we(sw_we),
    .i_extpin_flag_sw_val(sw_val),
    .o_extpin_request_flag(ext_flag),
    .i_insn_boundary(boundary),
    .i_return_from_service(ret),
    .o_vector_valid(vec_valid),
    .o_vector_addr(vec_addr),
    .o_vector_num(vec_num),
    .o_service_ack(ack),
    .o_in_service(in_svc)
  );

  iev_core_model i_iev_core_model (
    .i_clk(clk),
    .i_rst(rst),
    .i_vector_valid(vec_valid),
    .i_slow(slow),
    .i_svc_len(svc_len),
    .o_insn_boundary(boundary),
    .o_return_from_service(ret),
    .o_depth(depth)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr.wr <= 1'h1;
    sfr.addr <= a;
    sfr.wdata <= d;
    @(posedge clk);
    sfr.wr <= 1'h0;
  endtask : sfr_wr

  task automatic bit_wr(input logic [7:0] b, input logic v);
    @(posedge clk);
    sfr.bit_wr <= 1'h1;
    sfr.bit_addr <= b;
    sfr.bit_val <= v;
    @(posedge clk);
    sfr.bit_wr <= 1'h0;
  endtask : bit_wr

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk);
    sfr.rd <= 1'h1;
    sfr.addr <= a;
    @(posedge clk);
    sfr.rd <= 1'h0;
    #1;
    chk(18'(rdata), 18'(e), "read data");
    chk(18'(hit), 18'(h), "read hit");
  endtask : sfr_rd

  task automatic set_src(input int n, input logic v);
    case (n)
      0, 2: pin_n[n/2] <= ~v;
      1: flags.timer0_overflow_flag <= v;
      3: flags.timer1_overflow_flag <= v;
      4: flags.serial0[0] <= v;
      5: flags.timer2_flags[0] <= v;
      6: flags.twowire_timeout_flag <= v;
      7: flags.pinchange_flag_reg[5] <= v;
      8: flags.brownout_flag <= v;
      10: flags.watchdog_flag <= v;
      11: flags.conv_done_flag <= v;
      12, 13, 14: flags.timer2_flags[n-11] <= v;
      15: flags.serial1[1] <= v;
      16: flags.timer3_overflow_flag <= v;
      17: flags.wakeup_timer_flag <= v;
      default: ;
    endcase
  endtask : set_src

  task automatic wait_vec(input int n);
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (vec_valid !== 1'h1 && k < 400);
    chk(18'(vec_valid), 18'h1, "vector taken");
    chk(18'(vec_num), 18'(n), "vector number");
    chk(18'(vec_addr), 18'h3 + 18'(n) * 18'h8, "vector address");
    chk(ack, 18'h1 << n, "service ack");
  endtask : wait_vec

  task automatic serve(input int n);
    wait_vec(n);
    @(posedge clk);
    set_src(n, 1'h0);
  endtask : serve

  task automatic no_vec(input int c);
    repeat (c)
    begin
      @(posedge clk);
      #1;
      chk(18'(vec_valid), 18'h0, "no vector");
    end
  endtask : no_vec

  initial
  begin
    sfr = '0;
    flags = '0;
    prio_high = '0;
    prio_low = '0;
    pin_n = 2'h3;
    edge_sel = 2'h0;
    sw_we = 2'h0;
    sw_val = 2'h0;
    slow = 1'h0;
    svc_len = 8'h0a;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    #1;
    chk(18'(vec_addr), 18'h0, "reset vector");
    sfr_rd(8'ha8, 8'h00, 1'h1);
    sfr_rd(8'h9b, 8'h00, 1'h1);
    sfr_rd(8'h9c, 8'h00, 1'h1);
    sfr_wr(8'ha8, 8'h7f);
    sfr_wr(8'h9b, 8'hff);
    sfr_wr(8'h9c, 8'hff);
    sfr_rd(8'ha8, 8'h7f, 1'h1);
    sfr_rd(8'h9b, 8'hbf, 1'h1);
    sfr_rd(8'h9c, 8'h07, 1'h1);
    sfr_rd(8'h9d, 8'h00, 1'h0);
    $display("test registers done");
    @(posedge clk);
    set_src(1, 1'h1);
    set_src(8, 1'h1);
    set_src(10, 1'h1);
    no_vec(8);
    bit_wr(8'haf, 1'h1);
    serve(8);
    serve(10);
    serve(1);
    $display("test pending and tie done");
    @(posedge clk);
    slow <= 1'h1;
    for (int n = 0; n < 18; n++)
      if (n != 9)
      begin
        @(posedge clk);
        set_src(n, 1'h1);
        serve(n);
      end
    no_vec(40);
    chk(18'(in_svc), 18'h0, "all returned");
    $display("test vector table done");
    @(posedge clk);
    slow <= 1'h0;
    svc_len <= 8'h3c;
    prio_low <= 18'h0000a;
    prio_high <= 18'h00100;
    set_src(1, 1'h1);
    serve(1);
    #1;
    chk(18'(in_svc), 18'h2, "level one busy");
    @(posedge clk);
    set_src(3, 1'h1);
    no_vec(12);
    @(posedge clk);
    set_src(8, 1'h1);
    serve(8);
    #1;
    chk(18'(in_svc), 18'h6, "nested levels");
    serve(3);
    #1;
    chk(18'(depth), 18'h1, "outer routines done");
    $display("test preemption done");
    @(posedge clk);
    svc_len <= 8'h0a;
    prio_low <= '0;
    prio_high <= '0;
    edge_sel <= 2'h2;
    @(posedge clk);
    pin_n <= 2'h1;
    wait_vec(2);
    @(posedge clk);
    #1;
    chk(18'(ext_flag), 18'h0, "edge flag cleared");
    @(posedge clk);
    pin_n <= 2'h3;
    sw_we <= 2'h2;
    sw_val <= 2'h2;
    @(posedge clk);
    sw_we <= 2'h0;
    serve(2);
    bit_wr(8'haf, 1'h0);
    @(posedge clk);
    edge_sel <= 2'h0;
    pin_n <= 2'h2;
    repeat (5) @(posedge clk);
    #1;
    chk(18'(ext_flag), 18'h1, "level flag set");
    @(posedge clk);
    pin_n <= 2'h3;
    repeat (5) @(posedge clk);
    #1;
    chk(18'(ext_flag), 18'h0, "level flag clear");
    $display("test external pins done");
    @(posedge clk);
    prio_high <= 18'h20001;
    prio_low <= 18'h20001;
    set_src(0, 1'h1);
    set_src(17, 1'h1);
    no_vec(6);
    bit_wr(8'haf, 1'h1);
    serve(0);
    serve(17);
    $display("test top level tie done");
    stop_test();
  end
endmodule : tb
